// ==== core/csf_status_reg.v ====
// Processor status flag register with core write port and AHB-Lite view
// Notes on behaviour
// - Eight-bit word holds ALU result flags and reset and wake cause flags.
// - An instruction may write the register like any file location, writable bits taking data.
// - If the writing instruction updates zero, half-carry or carry, those bits come from the flags.
// - Watchdog-expiry and sleep-entered flags ignore instruction writes.
// - File-clear clears bits 7 to 5, sets zero and keeps bits 4 to 0 otherwise.
// - Reset-cause flags tell comparator-wake, watchdog and pin-change resets apart from power-up.
//
// Implementation choices: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "csf_map.vh"
module csf_status_reg (
  // Clock and power-up reset
  input  wire        clk_sys_in,
  input  wire        reset_n_in,
  // Non power-up reset causes, one-cycle pulses
  input  wire        external_reset_pin_in,
  input  wire        wdt_reset_in,
  input  wire        pin_wake_reset_in,
  input  wire        cmp_wake_reset_in,
  // Watchdog and sleep events
  input  wire        wdt_clear_in,
  input  wire        sleep_in,
  // Instruction write port
  input  wire        wr_en_in,
  input  wire [7:0]  wr_data_in,
  input  wire        file_clear_instr_in,
  // ALU flag update
  input  wire        alu_upd_z_in,
  input  wire        alu_upd_dc_in,
  input  wire        alu_upd_c_in,
  input  wire        alu_zero_in,
  input  wire        alu_half_carry_in,
  input  wire        alu_carry_in,
  // Core read
  output wire [7:0]  flags_out,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  // Interrupt
  output wire        irq_out
);
  // Flag register and its next value
  reg  [7:0]  flags_reg;
  reg  [7:0]  flags_next;
  // Bus phase state
  reg         ph_wr_reg;
  reg  [31:0] ph_addr_reg;
  reg  [31:0] rd_data_next;
  // Interrupt block wires
  wire [3:0]  irq_stat;
  wire [3:0]  irq_mask;
  wire [3:0]  irq_clr;
  wire [3:0]  irq_event;
  // Decode strobes
  wire        other_reset;
  wire        sleep_event;
  wire        ahb_req;
  wire        ahb_rd_req;
  wire        ahb_flags_wr;
  wire        ahb_stat_wr;
  wire        ahb_mask_wr;

  // Masked byte write; read-only bits keep their stored value
  function [7:0] csf_merge_write;
    input [7:0] old_val;
    input [7:0] new_val;
    begin
      csf_merge_write = (old_val & ~`CSF_WR_MASK) | (new_val & `CSF_WR_MASK);
    end
  endfunction

  // Whole-word register match; byte lanes below a word are not decoded
  function csf_addr_hit;
    input [31:0] addr;
    input [31:0] ofs;
    begin
      csf_addr_hit = (addr == ofs);
    end
  endfunction

  // Upper three bits cleared together by a file-clear
  localparam CAUSE_HI = `CSF_BIT_PINWAKE;
  localparam CAUSE_LO = `CSF_BIT_RSVD;

  // Any non power-up reset cause
  assign other_reset = external_reset_pin_in | wdt_reset_in | pin_wake_reset_in
                     | cmp_wake_reset_in;

  // Core read port shows the flops directly
  assign flags_out   = flags_reg;

  // Flag next value; reset causes take priority over instruction writes
  always @* begin
    flags_next = flags_reg;
    if (other_reset) begin
      // Cause flags distinguish non power-up resets
      flags_next[`CSF_BIT_PINWAKE] = pin_wake_reset_in;
      flags_next[`CSF_BIT_CMPWAKE] = cmp_wake_reset_in;
      flags_next[`CSF_BIT_RSVD]    = 1'b0;
      // Only the watchdog time-out drops the expiry flag
      if (wdt_reset_in) begin
        flags_next[`CSF_BIT_WDEXP] = 1'b0;
      end
    end else begin
      if (file_clear_instr_in) begin
        // Cleared result is zero, hence the zero flag
        flags_next[CAUSE_HI:CAUSE_LO] = 3'h0;
        flags_next[`CSF_BIT_ZERO] = 1'b1;
      end else if (wr_en_in) begin
        // Read-only bits keep their value
        flags_next = csf_merge_write(flags_reg, wr_data_in);
      end else if (ahb_flags_wr) begin
        // Bus write loses to a core write in the same cycle
        flags_next = csf_merge_write(flags_reg, hwdata[7:0]);
      end
      // ALU flags override a written value
      if (alu_upd_z_in) begin
        flags_next[`CSF_BIT_ZERO] = alu_zero_in;
      end
      if (alu_upd_dc_in) begin
        flags_next[`CSF_BIT_HALF] = alu_half_carry_in;
      end
      if (alu_upd_c_in) begin
        flags_next[`CSF_BIT_CARRY] = alu_carry_in;
      end
      // Watchdog clear and sleep touch only the expiry and sleep bits
      if (wdt_clear_in) begin
        flags_next[`CSF_BIT_WDEXP] = 1'b1;
        flags_next[`CSF_BIT_SLEEP] = 1'b1;
      end else if (sleep_in) begin
        flags_next[`CSF_BIT_WDEXP] = 1'b1;
        flags_next[`CSF_BIT_SLEEP] = 1'b0;
      end
    end
  end

  // Power-up reset loads the power-on pattern
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flags_reg <= `CSF_FLAGS_RESET;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // Transfer start: selected, NONSEQ or SEQ, previous transfer done
  assign ahb_req    = hready & hsel & htrans[1];
  assign ahb_rd_req = ahb_req & ~hwrite;

  // AHB address phase capture; zero wait states
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ph_wr_reg   <= 1'b0;
      ph_addr_reg <= 32'h0000_0000;
    end else if (hready) begin
      ph_wr_reg   <= ahb_req & hwrite;
      ph_addr_reg <= haddr;
    end
  end

  // Never stalls and never errors, so one data phase per access
  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;

  // Data phase write strobes, one per mapped word
  assign ahb_flags_wr = ph_wr_reg & csf_addr_hit(ph_addr_reg, `CSF_OFS_FLAGS);
  assign ahb_stat_wr  = ph_wr_reg & csf_addr_hit(ph_addr_reg, `CSF_OFS_IRQ_STAT);
  assign ahb_mask_wr  = ph_wr_reg & csf_addr_hit(ph_addr_reg, `CSF_OFS_IRQ_MASK);
  assign irq_clr      = ahb_stat_wr ? hwdata[3:0] : 4'h0;

  // Read word of the addressed register, decoded in the address phase
  always @* begin
    if (csf_addr_hit(haddr, `CSF_OFS_FLAGS)) begin
      rd_data_next = {24'h00_0000, flags_next};
    end else if (csf_addr_hit(haddr, `CSF_OFS_IRQ_STAT)) begin
      rd_data_next = {28'h000_0000, irq_stat};
    end else if (csf_addr_hit(haddr, `CSF_OFS_IRQ_MASK)) begin
      rd_data_next = {28'h000_0000, irq_mask};
    end else begin
      rd_data_next = 32'h0000_0000; // Unmapped reads zero
    end
  end

  // Registered at the address phase edge so it stands the whole data phase
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hrdata <= 32'h0000_0000;
    end else if (ahb_rd_req) begin
      hrdata <= rd_data_next;
    end
  end

  // Sleep counts only when it actually lands in the flags
  assign sleep_event = sleep_in & ~other_reset & ~wdt_clear_in;

  // Events: pin wake, comparator wake, watchdog time-out, sleep entry
  assign irq_event   = {sleep_event, wdt_reset_in, cmp_wake_reset_in, pin_wake_reset_in};

  csf_irq #(.WIDTH(`CSF_IRQ_WIDTH)) u_irq (
    .clk_sys_in   (clk_sys_in),
    .reset_n_in   (reset_n_in),
    .event_in     (irq_event),
    .clear_in     (irq_clr),
    .mask_we_in   (ahb_mask_wr),
    .mask_data_in (hwdata[3:0]),
    .status_out   (irq_stat),
    .mask_out     (irq_mask),
    .irq_out      (irq_out)
  );
endmodule // csf_status_reg
`default_nettype wire

// ==== common/csf_map.vh ====
// Register offsets, field positions and reset values of the status flag block
`ifndef CSF_MAP_VH
`define CSF_MAP_VH
`define CSF_OFS_FLAGS      32'h0000_0000
`define CSF_OFS_IRQ_STAT   32'h0000_0004
`define CSF_OFS_IRQ_MASK   32'h0000_0008
`define CSF_BIT_PINWAKE    7
`define CSF_BIT_CMPWAKE    6
`define CSF_BIT_RSVD       5
`define CSF_BIT_WDEXP      4
`define CSF_BIT_SLEEP      3
`define CSF_BIT_ZERO       2
`define CSF_BIT_HALF       1
`define CSF_BIT_CARRY      0
`define CSF_FLAGS_RESET    8'h18
`define CSF_WR_MASK        8'he7
`define CSF_ALU_MASK       8'h07
`define CSF_IRQ_RESET      4'h0
`define CSF_IRQ_WIDTH      4
`endif

// ==== core/csf_irq.v ====
// Sticky event status with write-one-to-clear and mask gating
`timescale 1ns/1ps
`default_nettype none
module csf_irq #(
  parameter WIDTH = 4
) (
  // Clock and reset
  input  wire             clk_sys_in,
  input  wire             reset_n_in,
  // Events and software access
  input  wire [WIDTH-1:0] event_in,
  input  wire [WIDTH-1:0] clear_in,
  input  wire             mask_we_in,
  input  wire [WIDTH-1:0] mask_data_in,
  // State and interrupt
  output reg  [WIDTH-1:0] status_out,
  output reg  [WIDTH-1:0] mask_out,
  output wire             irq_out
);
  // Set wins over a clear arriving in the same cycle
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      status_out <= {WIDTH{1'b0}};
      mask_out   <= {WIDTH{1'b0}};
    end else begin
      status_out <= (status_out & ~clear_in) | event_in;
      if (mask_we_in) begin
        mask_out <= mask_data_in;
      end
    end
  end

  // Level interrupt while any unmasked bit stands
  assign irq_out = |(status_out & mask_out);
endmodule // csf_irq
`default_nettype wire

// ==== tb/csfr_checker_assertions.sv ====
// Port-level checks of the status flag register
`timescale 1ns/1ps
`default_nettype none
module csfr_checker (
  // Clock and power-up reset
  input wire logic       clk_sys_in,
  input wire logic       reset_n_in,
  // Reset causes and cause events
  input wire logic       external_reset_pin_in,
  input wire logic       wdt_reset_in,
  input wire logic       pin_wake_reset_in,
  input wire logic       cmp_wake_reset_in,
  input wire logic       wdt_clear_in,
  input wire logic       sleep_in,
  // Instruction writes and ALU updates
  input wire logic       wr_en_in,
  input wire logic       file_clear_instr_in,
  input wire logic       alu_upd_z_in,
  input wire logic       alu_upd_dc_in,
  input wire logic       alu_upd_c_in,
  input wire logic       alu_zero_in,
  input wire logic       alu_half_carry_in,
  input wire logic       alu_carry_in,
  input wire logic [7:0] wr_data_in,
  // Register under check
  input wire logic [7:0] flags_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  // Any non power-up reset cause, which overrides writes
  wire rst_any = external_reset_pin_in | wdt_reset_in | pin_wake_reset_in | cmp_wake_reset_in;
  wire alu_all = alu_upd_z_in & alu_upd_dc_in & alu_upd_c_in;
  sequence s_core_wr;
    wr_en_in && !file_clear_instr_in && !rst_any;
  endsequence
  property p_rst_val; $rose(reset_n_in) |-> flags_out == 8'h18; endproperty
  property p_wr; s_core_wr |=> flags_out[7:5] == $past(wr_data_in[7:5]); endproperty
  property p_ro; (wr_en_in || file_clear_instr_in) && !wdt_clear_in && !sleep_in
    && !wdt_reset_in |=> $stable(flags_out[4:3]); endproperty
  property p_alu; alu_all && !rst_any && !file_clear_instr_in |=> flags_out[2] ==
    $past(alu_zero_in) && flags_out[1] == $past(alu_half_carry_in) && flags_out[0] ==
    $past(alu_carry_in); endproperty
  property p_clr; file_clear_instr_in && !rst_any |=> flags_out[7:5] == 3'h0 && flags_out[2];
  endproperty
  property p_cause; rst_any |=> flags_out[7] == $past(pin_wake_reset_in) && flags_out[6] ==
    $past(cmp_wake_reset_in) && !flags_out[5]; endproperty
  property p_wdt_to; wdt_reset_in |=> !flags_out[4]; endproperty
  property p_wclr; wdt_clear_in && !rst_any |=> flags_out[4:3] == 2'h3; endproperty
  property p_sleep; sleep_in && !wdt_clear_in && !rst_any |=> flags_out[4:3] == 2'h2;
  endproperty
  a_rst_val: assert property (p_rst_val) else $error("bad reset value");
  a_wr: assert property (p_wr) else $error("write not taken");
  a_ro: assert property (p_ro) else $error("read-only bits written");
  a_alu: assert property (p_alu) else $error("alu flags not loaded");
  a_clr: assert property (p_clr) else $error("file clear wrong");
  a_cause: assert property (p_cause) else $error("reset cause wrong");
  a_wdt_to: assert property (p_wdt_to) else $error("expiry flag kept");
  a_wclr: assert property (p_wclr) else $error("watchdog clear wrong");
  a_sleep: assert property (p_sleep) else $error("sleep flags wrong");
endmodule // csfr_checker
bind csf_status_reg csfr_checker u_csfr_checker (
  .clk_sys_in            (clk_sys_in),
  .reset_n_in            (reset_n_in),
  .external_reset_pin_in (external_reset_pin_in),
  .wdt_reset_in          (wdt_reset_in),
  .pin_wake_reset_in     (pin_wake_reset_in),
  .cmp_wake_reset_in     (cmp_wake_reset_in),
  .wdt_clear_in          (wdt_clear_in),
  .sleep_in              (sleep_in),
  .wr_en_in              (wr_en_in),
  .file_clear_instr_in   (file_clear_instr_in),
  .alu_upd_z_in          (alu_upd_z_in),
  .alu_upd_dc_in         (alu_upd_dc_in),
  .alu_upd_c_in          (alu_upd_c_in),
  .alu_zero_in           (alu_zero_in),
  .alu_half_carry_in     (alu_half_carry_in),
  .alu_carry_in          (alu_carry_in),
  .wr_data_in            (wr_data_in),
  .flags_out             (flags_out)
);
`default_nettype wire

// ==== tb/cpu_status_flag_register_bench.sv ====
// Self-checking bench for the status flag register
`timescale 1ns/1ps
`default_nettype none
module cpu_status_flag_register_bench;
  logic        clk_sys_in, reset_n_in, hsel, hwrite;
  logic [7:0]  stb, m, d, wdat;
  logic [2:0]  upd, alu, u, a, hsize;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, rd;
  logic [3:0]  ist;
  wire  [31:0] hrdata;
  wire  [7:0]  flags_out;
  wire         hreadyout, hresp, irq_out;
  int          err_count, total_checks, k;
  // Strobes packed in one vector to keep the random loop short
  csf_status_reg dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .external_reset_pin_in(stb[7]), .wdt_reset_in(stb[6]), .pin_wake_reset_in(stb[5]),
    .cmp_wake_reset_in(stb[4]), .wdt_clear_in(stb[3]), .sleep_in(stb[2]),
    .file_clear_instr_in(stb[1]), .wr_en_in(stb[0]), .wr_data_in(wdat),
    .alu_upd_z_in(upd[2]), .alu_upd_dc_in(upd[1]), .alu_upd_c_in(upd[0]),
    .alu_zero_in(alu[2]), .alu_half_carry_in(alu[1]), .alu_carry_in(alu[0]),
    .flags_out(flags_out), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq_out(irq_out));
  // Clock and watchdog
  initial begin
    clk_sys_in = 0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    #20000;
    err_count++;
    $display("BAD %0t timeout", $time);
    finish_test;
  end
  task chk(input logic [31:0] g, e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Single AHB transfer, waits on ready in both phases
  task ahb(input logic w, input logic [31:0] ad, wv);
    @(posedge clk_sys_in);
    {hsel, htrans, haddr, hwrite, hsize} <= {1'b1, 2'h2, ad, w, 3'h2};
    @(posedge clk_sys_in);
    while (hreadyout !== 1'b1) @(posedge clk_sys_in);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, wv};
    @(posedge clk_sys_in);
    while (hreadyout !== 1'b1) @(posedge clk_sys_in);
    rd = hrdata;
    #1;
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Main sequence, model kept in m and ist
  initial begin
    {reset_n_in, hsel, hwrite, stb, upd, alu, wdat, htrans, hsize, haddr, hwdata} = 0;
    m = 8'h18;
    ist = 0;
    k = $urandom(50101);
    repeat (10) @(posedge clk_sys_in);
    reset_n_in <= 1;
    ahb(0, 0, 0);
    chk(rd, m);
    chk(hresp, 32'h0);
    chk(hreadyout, 32'h1);
    $display("reset test done");
    repeat (300) begin
      k = $urandom % 8;
      d = $urandom % 256;
      a = $urandom % 8;
      u = (k > 3 && k != 6) ? 3'($urandom % 8) : 3'h0;
      @(posedge clk_sys_in);
      {stb, wdat, alu, upd} <= {(8'h80 >> k) | 8'(k == 6), d, a, u};
      #1 chk(flags_out, m);
      if (k < 4) m[7:5] = {k == 2, k == 3, 1'b0};
      if (k == 1) m[4] = 0;
      if (k == 4) m[4:3] = 2'h3;
      if (k == 5) m[4:3] = 2'h2;
      if (k == 6) m = m & 8'h1f | 8'h04;
      if (k == 7) m = m & 8'h18 | d & 8'he7;
      m[2:0] = m[2:0] & ~u | a & u;
      ist = ist | {k == 5, k == 1, k == 3, k == 2};
    end
    @(posedge clk_sys_in);
    {stb, upd} <= 0;
    #1 chk(flags_out, m);
    $display("core test done");
    ahb(1, 0, 32'h9f);
    m = m & 8'h18 | 8'h87;
    chk(flags_out, m);
    ahb(0, 0, 0);
    chk(rd, m);
    ahb(0, 4, 0);
    chk(rd, ist);
    chk(irq_out, 0);
    ahb(1, 8, 32'hf);
    chk(irq_out, ist != 0);
    ahb(0, 8, 0);
    chk(rd, 32'hf);
    ahb(1, 4, 32'hf);
    chk(irq_out, 0);
    ahb(0, 4, 0);
    chk(rd, 0);
    ahb(1, 32'h10, 32'hff);
    ahb(0, 32'h10, 0);
    chk(rd, 0);
    $display("register test done");
    finish_test;
  end
endmodule // cpu_status_flag_register_bench
`default_nettype wire
